//--- design/csr_core_state.sv
// core special-register state: general registers, stacks, status words, masks
// Overview of operation
// - thirteen 32-bit general registers, readable and writable by any software.
// - thread mode control bit 1 picks main (0, reset) or process stack.
// - main stack pointer loads from word at address zero at reset.
// - link register loads fixed value at reset.
// - program counter bit 0 always reads zero.
// - program counter loads the reset vector word from address four.
// - status word holds flags, set-state bit, predication/continuation and exception number.
// - status views accessible singly, paired or all; exec+exception pair read-only.
// - exception number writes ignored; exec-state bits read zero, writes ignored.
// - negative flag follows result sign, zero flag set exactly on zero.
// - carry set on add carry or subtract without borrow.
// - overflow set when operation overflows, cleared otherwise.
// - saturation flag sticky until software clears or reset.
// - exception number field reports current exception, zero in thread.
// - execution status set-state bit always one, plus predication/continuation fields.
// - interrupted multi-register transfer records next register in bits 15:12.
// - while continuation state held, bits 26:25 and 11:10 read zero.
// - predication block covers up to four conditional instructions.
// - configurable-exception block bit blocks configurable-priority exceptions.
// - all-exception block bit blocks all exceptions.
// - exception exit other than non-maskable clears all-exception block bit.
// - both mask bits via register moves and interrupt state change instruction.
// - handler mode stack select reads zero and ignores writes.
// - core enters thread mode on leaving reset.
`timescale 1ns/1ps
`include "csr_params.svh"

module csr_core_state (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // reset vector fetch
   output logic                        vec_req,
   output logic [31:0]                 vec_addr,
   input  wire logic                   vec_valid,
   input  wire logic [31:0]            vec_data,
   output logic                        core_ready,
   // register access
   input  wire csr_pkg::csr_acc_s      acc,
   output logic [31:0]                 rdata,
   // flag updates
   input  wire csr_pkg::csr_flags_s    flags_in,
   // program counter
   input  wire logic                   pc_load,
   input  wire logic [31:0]            pc_value,
   output logic [31:0]                 program_counter,
   // exception entry and exit
   input  wire logic                   exc_enter,
   input  wire logic [8:0]             exc_num,
   input  wire logic                   exc_exit,
   input  wire logic [8:0]             exc_ret_num,
   // execution state save and restore
   input  wire logic                   exec_load,
   input  wire logic [7:0]             exec_value,
   input  wire logic                   xfer_suspend,
   input  wire logic [3:0]             xfer_next_reg,
   output logic [7:0]                  exec_state,
   output logic                        xfer_pending,
   output logic [3:0]                  xfer_resume_reg,
   // interrupt state change instruction
   input  wire logic                   isc_en,
   input  wire logic                   isc_disable,
   input  wire logic                   isc_prim,
   input  wire logic                   isc_fault,
   // status to the rest of the core
   output logic                        handler_mode,
   output logic                        use_process_stack,
   output logic [31:0]                 stack_pointer,
   output logic [31:0]                 status_word,
   output logic                        block_configurable,
   output logic                        block_all
);
   import csr_pkg::*;

   csr_state_e  state_reg;
   logic [31:0] gpr_reg [`CSR_NUM_GPR];
   logic [31:0] main_stack_pointer_reg;
   logic [31:0] process_stack_pointer_reg;
   logic [31:0] link_register_reg;
   logic [31:0] pc_reg;
   logic [4:0]  flags_reg;
   logic [8:0]  exc_reg;
   logic [7:0]  exec_reg;
   logic        sel_reg;
   logic        prim_reg;
   logic        fault_reg;
   logic        run;
   logic        wr;
   logic        flags_view_wr;
   logic        flags_view_rd;
   logic        exc_view_rd;
   logic        exec_view_rd;
   logic [31:0] exec_bits;

   assign run  = (state_reg == CSR_ST_RUN);
   assign wr   = acc.wr && run;

   // reset vector fetch sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= CSR_ST_RESET_SP;
      end else begin
         case (state_reg)
            CSR_ST_RESET_SP: begin
               if (vec_valid) begin
                  state_reg <= CSR_ST_RESET_PC;
               end
            end
            CSR_ST_RESET_PC: begin
               if (vec_valid) begin
                  state_reg <= CSR_ST_RUN;
               end
            end
            CSR_ST_RUN: state_reg <= CSR_ST_RUN;
            default:    state_reg <= CSR_ST_RESET_SP;
         endcase
      end
   end

   assign vec_req    = !run;
   assign vec_addr   = (state_reg == CSR_ST_RESET_SP) ? `CSR_VEC_SP_ADDR
                                                     : `CSR_VEC_PC_ADDR;
   assign core_ready = run;

   // general registers
   genvar gi;
   generate
      for (gi = 0; gi < `CSR_NUM_GPR; gi++) begin : g_gpr
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               gpr_reg[gi] <= 32'h0000_0000;
            end else if (wr && acc.sel == CSR_SEL_GPR && acc.gpr_idx == 4'(gi)) begin
               gpr_reg[gi] <= acc.wdata;
            end
         end
      end
   endgenerate

   // stack pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         main_stack_pointer_reg <= 32'h0000_0000;
      end else if (state_reg == CSR_ST_RESET_SP && vec_valid) begin
         main_stack_pointer_reg <= vec_data;
      end else if (wr && (acc.sel == CSR_SEL_MAIN_SP ||
                          (acc.sel == CSR_SEL_SP && !use_process_stack))) begin
         main_stack_pointer_reg <= acc.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         process_stack_pointer_reg <= 32'h0000_0000;
      end else if (wr && (acc.sel == CSR_SEL_PROC_SP ||
                          (acc.sel == CSR_SEL_SP && use_process_stack))) begin
         process_stack_pointer_reg <= acc.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link_register_reg <= `CSR_LINK_RESET;
      end else if (wr && acc.sel == CSR_SEL_LINK) begin
         link_register_reg <= acc.wdata;
      end
   end

   // program counter, halfword aligned
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= 32'h0000_0000;
      end else if (state_reg == CSR_ST_RESET_PC && vec_valid) begin
         pc_reg <= {vec_data[31:1], 1'b0};
      end else if (run && pc_load) begin
         pc_reg <= {pc_value[31:1], 1'b0};
      end else if (wr && acc.sel == CSR_SEL_PC) begin
         pc_reg <= {acc.wdata[31:1], 1'b0};
      end
   end

   assign program_counter = pc_reg;

   // flag views that accept writes
   assign flags_view_wr = (acc.sel == CSR_SEL_FLAGS) || (acc.sel == CSR_SEL_FLAGS_EXC) ||
                          (acc.sel == CSR_SEL_FLAGS_EXEC) || (acc.sel == CSR_SEL_STATUS);
   assign flags_view_rd = flags_view_wr;
   assign exc_view_rd   = (acc.sel == CSR_SEL_EXCNUM) || (acc.sel == CSR_SEL_FLAGS_EXC) ||
                          (acc.sel == CSR_SEL_EXEC_EXC) || (acc.sel == CSR_SEL_STATUS);
   assign exec_view_rd  = (acc.sel == CSR_SEL_EXEC) || (acc.sel == CSR_SEL_FLAGS_EXEC) ||
                          (acc.sel == CSR_SEL_EXEC_EXC) || (acc.sel == CSR_SEL_STATUS);

   // condition flags; saturation is sticky, set wins over software clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= 5'h00;
      end else begin
         if (wr && flags_view_wr) begin
            flags_reg <= acc.wdata[`CSR_FLAG_N:`CSR_FLAG_Q];
         end
         if (run && flags_in.upd_nz) begin
            flags_reg[4] <= flags_in.result_neg;
            flags_reg[3] <= flags_in.result_zero;
         end
         if (run && flags_in.upd_c) begin
            flags_reg[2] <= flags_in.carry;
         end
         if (run && flags_in.upd_v) begin
            flags_reg[1] <= flags_in.overflow;
         end
         if (run && flags_in.saturated) begin
            flags_reg[0] <= 1'b1;
         end
      end
   end

   // exception number; software writes never reach it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         exc_reg <= `CSR_EXC_THREAD;
      end else if (run && exc_enter) begin
         exc_reg <= exc_num;
      end else if (run && exc_exit) begin
         exc_reg <= exc_ret_num;
      end
   end

   assign handler_mode = (exc_reg != `CSR_EXC_THREAD);

   // predication / continuation state, hardware only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         exec_reg <= 8'h00;
      end else if (run && xfer_suspend) begin
         exec_reg <= {2'b00, xfer_next_reg, 2'b00};
      end else if (run && exec_load) begin
         exec_reg <= exec_value;
      end
   end

   assign exec_state      = exec_reg;
   assign xfer_pending    = (exec_reg[7:6] == 2'b00) && (exec_reg[1:0] == 2'b00) &&
                            (exec_reg[5:2] != 4'h0);
   assign xfer_resume_reg = exec_reg[5:2];
   assign exec_bits       = {5'h00, exec_reg[7:6], 1'b1, 8'h00, exec_reg[5:0], 10'h000};

   // stack select: writes ignored in handler mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_reg <= 1'b0;
      end else if (wr && acc.sel == CSR_SEL_CONTROL && !handler_mode) begin
         sel_reg <= acc.wdata[`CSR_SEL_BIT];
      end
   end

   assign use_process_stack = sel_reg && !handler_mode;
   assign stack_pointer     = use_process_stack ? process_stack_pointer_reg
                                                : main_stack_pointer_reg;

   // exception mask bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prim_reg <= 1'b0;
      end else if (run && isc_en && isc_prim) begin
         prim_reg <= isc_disable;
      end else if (wr && acc.sel == CSR_SEL_PRIM) begin
         prim_reg <= acc.wdata[0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_reg <= 1'b0;
      end else if (run && exc_exit && exc_reg != `CSR_EXC_NMI) begin
         fault_reg <= 1'b0;
      end else if (run && isc_en && isc_fault) begin
         fault_reg <= isc_disable;
      end else if (wr && acc.sel == CSR_SEL_FAULT) begin
         fault_reg <= acc.wdata[0];
      end
   end

   assign block_configurable = prim_reg;
   assign block_all          = fault_reg;

   assign status_word = {flags_reg, 27'h0} | exec_bits | {23'h0, exc_reg};

   // read mux; exec bits never visible to software
   always_comb begin
      rdata = 32'h0000_0000;
      case (acc.sel)
         CSR_SEL_GPR: begin
            if (acc.gpr_idx < 4'(`CSR_NUM_GPR)) begin
               rdata = gpr_reg[acc.gpr_idx];
            end
         end
         CSR_SEL_SP:      rdata = stack_pointer;
         CSR_SEL_MAIN_SP: rdata = main_stack_pointer_reg;
         CSR_SEL_PROC_SP: rdata = process_stack_pointer_reg;
         CSR_SEL_LINK:    rdata = link_register_reg;
         CSR_SEL_PC:      rdata = {pc_reg[31:1], 1'b0};
         CSR_SEL_PRIM:    rdata = {31'h0, prim_reg};
         CSR_SEL_FAULT:   rdata = {31'h0, fault_reg};
         CSR_SEL_CONTROL: rdata = {30'h0, use_process_stack, 1'b0};
         default: begin
            if (flags_view_rd) begin
               rdata = rdata | {flags_reg, 27'h0};
            end
            if (exc_view_rd) begin
               rdata = rdata | {23'h0, exc_reg};
            end
            if (exec_view_rd) begin
               rdata = rdata;
            end
         end
      endcase
   end

   // assertions
   property pc_align_p;
      @(posedge clk) disable iff (!rst_n) program_counter[0] == 1'b0;
   endproperty
   pc_even_a: assert property (pc_align_p) else $error("pc bit 0 set");

   sticky_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
      flags_reg[0] && !(acc.wr && run && flags_view_wr) |=> flags_reg[0])
      else $error("saturation flag lost");

   fault_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      run && exc_exit && exc_reg != `CSR_EXC_NMI |=> !block_all)
      else $error("fault block not cleared on exit");

   handler_stack_a: assert property (@(posedge clk) disable iff (!rst_n)
      handler_mode |-> !use_process_stack)
      else $error("process stack in handler mode");

   tbit_one_a: assert property (@(posedge clk) disable iff (!rst_n)
      status_word[`CSR_TBIT])
      else $error("set-state bit not one");

   exc_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !exc_enter && !exc_exit |=> $stable(exc_reg))
      else $error("exception number changed by software");

   sequence suspend_s;
      run && xfer_suspend;
   endsequence
   icl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      suspend_s |=> status_word[26:25] == 2'b00 && status_word[11:10] == 2'b00
                    && xfer_resume_reg == $past(xfer_next_reg))
      else $error("continuation state malformed");

   zero_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      run && flags_in.upd_nz |=> status_word[`CSR_FLAG_Z] == $past(flags_in.result_zero))
      else $error("zero flag wrong");

   carry_a: assert property (@(posedge clk) disable iff (!rst_n)
      run && flags_in.upd_c |=> status_word[`CSR_FLAG_C] == $past(flags_in.carry))
      else $error("carry flag wrong");

   ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
      run && flags_in.upd_v |=> status_word[`CSR_FLAG_V] == $past(flags_in.overflow))
      else $error("overflow flag wrong");

   main_sp_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == CSR_ST_RESET_SP && vec_valid
      |=> main_stack_pointer_reg == $past(vec_data))
      else $error("main stack pointer not loaded");

   isc_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
      run && isc_en && isc_fault && !exc_exit |=> block_all == $past(isc_disable))
      else $error("fault block ignores state change");

endmodule

//--- design/csr_params.svh
// constants for the core special-register state block
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

`define CSR_VEC_SP_ADDR    32'h0000_0000
`define CSR_VEC_PC_ADDR    32'h0000_0004
`define CSR_LINK_RESET     32'h0fff_ffff
`define CSR_STATUS_RESET   32'h0100_0000
`define CSR_FLAG_N         31
`define CSR_FLAG_Z         30
`define CSR_FLAG_C         29
`define CSR_FLAG_V         28
`define CSR_FLAG_Q         27
`define CSR_TBIT           24
`define CSR_EXC_NMI        9'h002
`define CSR_EXC_THREAD     9'h000
`define CSR_FLAGS_MASK     32'hf800_0000
`define CSR_EXEC_MASK      32'h0700_fc00
`define CSR_EXC_MASK       32'h0000_01ff
`define CSR_SEL_BIT        1
`define CSR_NUM_GPR        13

`endif

//--- design/csr_pkg.sv
// types for the core special-register state block
package csr_pkg;

   typedef enum logic [3:0] {
      CSR_SEL_GPR        = 4'h0,
      CSR_SEL_SP         = 4'h1,
      CSR_SEL_MAIN_SP    = 4'h2,
      CSR_SEL_PROC_SP    = 4'h3,
      CSR_SEL_LINK       = 4'h4,
      CSR_SEL_PC         = 4'h5,
      CSR_SEL_FLAGS      = 4'h6,
      CSR_SEL_EXCNUM     = 4'h7,
      CSR_SEL_EXEC       = 4'h8,
      CSR_SEL_FLAGS_EXC  = 4'h9,
      CSR_SEL_FLAGS_EXEC = 4'ha,
      CSR_SEL_EXEC_EXC   = 4'hb,
      CSR_SEL_STATUS     = 4'hc,
      CSR_SEL_PRIM       = 4'hd,
      CSR_SEL_FAULT      = 4'he,
      CSR_SEL_CONTROL    = 4'hf
   } csr_sel_e;

   typedef enum logic [1:0] {
      CSR_ST_RESET_SP = 2'b00,
      CSR_ST_RESET_PC = 2'b01,
      CSR_ST_RUN      = 2'b10
   } csr_state_e;

   // register access from the execute stage
   typedef struct packed {
      logic        wr;
      csr_sel_e    sel;
      logic [3:0]  gpr_idx;
      logic [31:0] wdata;
   } csr_acc_s;

   // flag results from the execute stage
   typedef struct packed {
      logic upd_nz;
      logic upd_c;
      logic upd_v;
      logic result_neg;
      logic result_zero;
      logic carry;
      logic overflow;
      logic saturated;
   } csr_flags_s;

endpackage

//--- testbench/test_csr_core_state.sv
// self-checking bench for the core special-register state block
`timescale 1ns/1ps
`include "csr_params.svh"

module test_csr_core_state;
   import csr_pkg::*;

   typedef struct {
      int          k;
      logic [31:0] e;
   } csr_note_s;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        vec_req, vec_valid, core_ready, pc_load, exc_enter, exc_exit;
   logic        exec_load, xfer_suspend, xfer_pending, isc_en, isc_disable, isc_prim;
   logic        isc_fault, handler_mode, use_process_stack, block_configurable, block_all;
   logic [31:0] vec_addr, vec_data, rdata, pc_value, program_counter, stack_pointer;
   logic [31:0] status_word;
   logic [8:0]  exc_num, exc_ret_num;
   logic [7:0]  exec_value, exec_state;
   logic [3:0]  xfer_next_reg, xfer_resume_reg;
   csr_acc_s    acc;
   csr_flags_s  flags_in;
   csr_note_s   expq[$];
   event        chk_ev;
   int          failures = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   logic [31:0] main_sp_v, proc_sp_v, pc_v, d;
   logic [31:0] gpr_v [13];
   logic [8:0]  codes [10] = '{9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h00b, 9'h00e,
                                9'h00f, 9'h010, 9'h02f};
   string       kname [14] = '{"rdata", "program_counter", "stack_pointer", "status_word",
                               "vec_addr", "handler_mode", "use_process_stack",
                               "block_configurable", "block_all", "xfer_pending",
                               "xfer_resume_reg", "core_ready", "exec_state", "vec_req"};

   always #2.5 clk = ~clk;

   csr_core_state i_csr_core_state (
      .clk(clk), .rst_n(rst_n), .vec_req(vec_req), .vec_addr(vec_addr),
      .vec_valid(vec_valid), .vec_data(vec_data), .core_ready(core_ready), .acc(acc),
      .rdata(rdata), .flags_in(flags_in), .pc_load(pc_load), .pc_value(pc_value),
      .program_counter(program_counter), .exc_enter(exc_enter), .exc_num(exc_num),
      .exc_exit(exc_exit), .exc_ret_num(exc_ret_num), .exec_load(exec_load),
      .exec_value(exec_value), .xfer_suspend(xfer_suspend), .xfer_next_reg(xfer_next_reg),
      .exec_state(exec_state), .xfer_pending(xfer_pending),
      .xfer_resume_reg(xfer_resume_reg), .isc_en(isc_en), .isc_disable(isc_disable),
      .isc_prim(isc_prim), .isc_fault(isc_fault), .handler_mode(handler_mode),
      .use_process_stack(use_process_stack), .stack_pointer(stack_pointer),
      .status_word(status_word), .block_configurable(block_configurable),
      .block_all(block_all)
   );

   function automatic logic [31:0] got(input int k);
      case (k)
         0: return rdata;
         1: return program_counter;
         2: return stack_pointer;
         3: return status_word;
         4: return vec_addr;
         5: return {31'h0, handler_mode};
         6: return {31'h0, use_process_stack};
         7: return {31'h0, block_configurable};
         8: return {31'h0, block_all};
         9: return {31'h0, xfer_pending};
         10: return {28'h0, xfer_resume_reg};
         11: return {31'h0, core_ready};
         12: return {24'h0, exec_state};
         default: return {31'h0, vec_req};
      endcase
   endfunction

   task automatic cmp32(input int k, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", kname[k], e, g);
      end
   endtask

   // monitor: oldest note against the output it names
   always @(chk_ev) begin
      while (expq.size() > 0) begin
         csr_note_s n;
         n = expq.pop_front();
         cmp32(n.k, n.e, got(n.k));
      end
   end

   task automatic chk(input int k, input logic [31:0] e);
      #1;
      expq.push_back('{k, e});
      ->chk_ev;
   endtask

   task automatic wr(input csr_sel_e s, input logic [3:0] i, input logic [31:0] v);
      @(negedge clk);
      acc <= '{1'b1, s, i, v};
      @(negedge clk);
      acc.wr <= 1'b0;
   endtask

   task automatic rd(input csr_sel_e s, input logic [3:0] i, input logic [31:0] e);
      @(negedge clk);
      acc <= '{1'b0, s, i, 32'h0};
      chk(0, e);
   endtask

   task automatic fl(input logic n, input logic z, input logic c, input logic v,
                     input logic s);
      @(negedge clk);
      flags_in <= '{1'b1, 1'b1, 1'b1, n, z, c, v, s};
      @(negedge clk);
      flags_in <= '0;
   endtask

   task automatic isc(input logic dis, input logic p, input logic f);
      @(negedge clk);
      {isc_en, isc_disable, isc_prim, isc_fault} <= {1'b1, dis, p, f};
      @(negedge clk);
      isc_en <= 1'b0;
   endtask

   task automatic test_end(input string s);
      $display("test %s done", s);
   endtask

   task automatic final_report();
      #1;
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         final_report();
      end
   end

   initial begin
      acc = '0;
      flags_in = '0;
      {vec_valid, pc_load, exc_enter, exc_exit, exec_load, xfer_suspend} = '0;
      {isc_en, isc_disable, isc_prim, isc_fault} = '0;
      {vec_data, pc_value, exc_num, exc_ret_num, exec_value, xfer_next_reg} = '0;
      void'($urandom(32'hd8617482));
      main_sp_v = $urandom & 32'hffff_fffc;
      pc_v = $urandom | 32'h1;
      repeat (9) @(negedge clk);
      chk(4, `CSR_VEC_SP_ADDR);
      chk(3, `CSR_STATUS_RESET);
      chk(13, 32'h1);
      chk(11, 32'h0);
      @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      vec_valid <= 1'b1;
      vec_data <= main_sp_v;
      @(negedge clk);
      vec_data <= pc_v;
      chk(4, `CSR_VEC_PC_ADDR);
      @(negedge clk);
      vec_valid <= 1'b0;
      for (int j = 0; j < 4 && core_ready !== 1'b1; j++) @(negedge clk);
      chk(11, 32'h1);
      chk(13, 32'h0);
      chk(1, pc_v & 32'hffff_fffe);
      rd(CSR_SEL_MAIN_SP, 4'h0, main_sp_v);
      rd(CSR_SEL_LINK, 4'h0, `CSR_LINK_RESET);
      chk(2, main_sp_v);
      chk(5, 32'h0);
      rd(CSR_SEL_STATUS, 4'h0, 32'h0);
      test_end("reset");
      for (int j = 0; j < 13; j++) begin
         gpr_v[j] = $urandom;
         wr(CSR_SEL_GPR, 4'(j), gpr_v[j]);
      end
      for (int j = 0; j < 13; j++) rd(CSR_SEL_GPR, 4'(j), gpr_v[j]);
      wr(CSR_SEL_GPR, 4'hd, $urandom);
      rd(CSR_SEL_GPR, 4'hd, 32'h0);
      @(negedge clk);
      {pc_load, pc_value} <= {1'b1, 32'h0000_1235};
      @(negedge clk);
      pc_load <= 1'b0;
      chk(1, 32'h0000_1234);
      test_end("general");
      proc_sp_v = $urandom & 32'hffff_fffc;
      wr(CSR_SEL_PROC_SP, 4'h0, proc_sp_v);
      wr(CSR_SEL_CONTROL, 4'h0, 32'h2);
      chk(6, 32'h1);
      chk(2, proc_sp_v);
      wr(CSR_SEL_CONTROL, 4'h0, 32'h0);
      chk(2, main_sp_v);
      test_end("stack");
      fl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      for (int j = 0; j < 6; j++) begin
         d = $urandom;
         fl(d[3], d[2], d[1], d[0], 1'b0);
         rd(CSR_SEL_FLAGS, 4'h0, {d[3:0], 1'b1, 27'h0});
      end
      wr(CSR_SEL_FLAGS, 4'h0, 32'h0);
      rd(CSR_SEL_FLAGS, 4'h0, 32'h0);
      test_end("flags");
      wr(CSR_SEL_STATUS, 4'h0, 32'hffff_ffff);
      rd(CSR_SEL_STATUS, 4'h0, 32'hf800_0000);
      chk(3, 32'hf900_0000);
      rd(CSR_SEL_EXEC, 4'h0, 32'h0);
      rd(CSR_SEL_EXCNUM, 4'h0, 32'h0);
      wr(CSR_SEL_EXEC_EXC, 4'h0, 32'h0);
      rd(CSR_SEL_FLAGS, 4'h0, 32'hf800_0000);
      wr(CSR_SEL_FLAGS_EXC, 4'h0, 32'h3800_01ff);
      rd(CSR_SEL_FLAGS_EXC, 4'h0, 32'h3800_0000);
      wr(CSR_SEL_FLAGS_EXEC, 4'h0, 32'h0);
      rd(CSR_SEL_FLAGS_EXEC, 4'h0, 32'h0);
      test_end("views");
      // process stack chosen in thread mode, so handler mode must hide it
      wr(CSR_SEL_CONTROL, 4'h0, 32'h2);
      foreach (codes[j]) begin
         wr(CSR_SEL_FAULT, 4'h0, 32'h1);
         @(negedge clk);
         {exc_enter, exc_num} <= {1'b1, codes[j]};
         @(negedge clk);
         exc_enter <= 1'b0;
         chk(5, 32'h1);
         rd(CSR_SEL_EXCNUM, 4'h0, {23'h0, codes[j]});
         chk(3, {23'h00_8000, codes[j]});
         wr(CSR_SEL_CONTROL, 4'h0, 32'h0);
         rd(CSR_SEL_CONTROL, 4'h0, 32'h0);
         chk(2, main_sp_v);
         @(negedge clk);
         {exc_exit, exc_ret_num} <= {1'b1, 9'h000};
         @(negedge clk);
         exc_exit <= 1'b0;
         chk(5, 32'h0);
         chk(6, 32'h1);
         chk(8, {31'h0, codes[j] == 9'h002});
      end
      wr(CSR_SEL_CONTROL, 4'h0, 32'h0);
      test_end("exceptions");
      @(negedge clk);
      {exec_load, exec_value} <= {1'b1, 8'hc3};
      @(negedge clk);
      exec_load <= 1'b0;
      chk(3, 32'h0700_0c00);
      chk(12, 32'h0000_00c3);
      rd(CSR_SEL_EXEC, 4'h0, 32'h0);
      @(negedge clk);
      {xfer_suspend, xfer_next_reg, exec_load} <= {1'b1, 4'h5, 1'b1};
      @(negedge clk);
      {xfer_suspend, exec_load} <= 2'b00;
      chk(9, 32'h1);
      chk(10, 32'h5);
      chk(3, 32'h0100_5000);
      wr(CSR_SEL_EXEC, 4'h0, 32'hffff_ffff);
      chk(3, 32'h0100_5000);
      test_end("execution");
      wr(CSR_SEL_PRIM, 4'h0, 32'hffff_ffff);
      rd(CSR_SEL_PRIM, 4'h0, 32'h1);
      chk(7, 32'h1);
      wr(CSR_SEL_FAULT, 4'h0, 32'hffff_ffff);
      rd(CSR_SEL_FAULT, 4'h0, 32'h1);
      chk(8, 32'h1);
      isc(1'b0, 1'b1, 1'b1);
      chk(7, 32'h0);
      chk(8, 32'h0);
      isc(1'b1, 1'b0, 1'b1);
      chk(7, 32'h0);
      chk(8, 32'h1);
      isc(1'b1, 1'b1, 1'b0);
      rd(CSR_SEL_PRIM, 4'h0, 32'h1);
      test_end("masks");
      final_report();
   end
endmodule
